// [hw/eeprom_pkg.sv]
/*
 Constants, opcodes, status layout and types of the serial EEPROM front end.
 Assumes a 40 MHz system clock; the SPI pins are sampled, never used as clocks.
*/
package eeprom_pkg;
    // System clock and self-timed write cycle
    localparam int CLK_MHZ = 40;
    localparam int TW_US = 5000;
    localparam int TW_CYCLES = TW_US * CLK_MHZ;
    localparam int TW_W = 20;

    // Opcodes
    localparam logic [7:0] OPC_ARM = 8'h06;
    localparam logic [7:0] OPC_DISARM = 8'h04;
    localparam logic [7:0] OPC_SREAD = 8'h05;
    localparam logic [7:0] OPC_SWRITE = 8'h01;
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_WRITE = 8'h02;
    localparam logic [7:0] OPC_XREAD = 8'h83;
    localparam logic [7:0] OPC_XWRITE = 8'h82;

    // Status register bit positions and reset values
    localparam int ST_BUSY = 0;
    localparam int ST_WLATCH = 1;
    localparam int ST_GUARD_LO = 2;
    localparam int ST_GUARD_HI = 3;
    localparam int ST_LOCK = 7;
    localparam logic [1:0] GUARD_RST = 2'h0;
    localparam logic LOCK_RST = 1'b0;

    // Protected region bases within the 32K array
    localparam logic [14:0] QUARTER_BASE = 15'h6000;
    localparam logic [14:0] HALF_BASE = 15'h4000;

    // Byte index within an instruction, saturating
    localparam logic [2:0] BYTE_OPC = 3'h0;
    localparam logic [2:0] BYTE_AHI = 3'h1;
    localparam logic [2:0] BYTE_ALO = 3'h2;
    localparam logic [2:0] BYTE_DATA = 3'h3;
    localparam logic [2:0] BYTE_SAT = 3'h4;

    // Synchroniser lanes and their idle levels
    localparam int SY_CS = 0;
    localparam int SY_SCK = 1;
    localparam int SY_SI = 2;
    localparam int SY_HOLD = 3;
    localparam int SY_WP = 4;
    localparam logic [4:0] SYNC_RST = 5'h19;

    // Write queue
    localparam int FIFO_DEPTH = 8;
    localparam int WORD_W = 28;

    typedef enum logic [3:0] {
        OP_NONE, OP_ARM, OP_DISARM, OP_SREAD, OP_SWRITE, OP_READ, OP_WRITE, OP_XREAD, OP_XWRITE
    } op_t;
    typedef enum logic [1:0] {SP_ARRAY, SP_SECTOR, SP_UID, SP_LOCK} space_t;
    typedef enum logic [1:0] {K_DATA, K_COMMIT, K_ABORT} kind_t;
endpackage

// [hw/spi_eeprom_cmd_protect.sv]
/*
 SPI slave front end of a serial EEPROM: framing, pause, decode, status and protection,
 plus the write queue toward the array. Assumes the array answers rd_data within two
 clocks of rd_addr/rd_space and drains the queue; SPI clock well below sys_clk / 6.
*/
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Write queue; DEPTH a power of two
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire do_wr = in_valid & in_ready;
    wire do_rd = out_valid & out_ready;

    assign in_ready = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_q + AW'(do_wr);
            rd_q <= rd_q + AW'(do_rd);
            cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Input sampled on clock rise, output driven on clock fall.
// - Clock idle low (mode 0) or high (mode 3) both work.
// - Pause starts at pause fall if clock low, else after next clock fall.
// - Pause ends at pause rise if clock low, else after next clock fall.
// - While paused output floats, input and clock ignored, state kept.
// - Reset leaves the device write-disabled, write latch clear.
// - Memory or status writes need the write latch set beforehand.
// - Writing instructions execute only if select rises on a byte boundary.
// - Busy flag is set during every internal write cycle, clear after.
// - While busy only status read is accepted.
// - Write latch flag is read-only and set by arm-write.
// - Write latch clears on disarm and every executed writing instruction.
// - Region-guard bits default 0 and are written by status write.
// - Guard 01 top quarter, 10 top half, 11 whole array protected.
// - Lock bit set with protect pin low rejects status write.
// - Instruction starts at select fall; opcode first, MSB first.
// - Select rise ends any instruction; reads may stop on any bit.
// - Decode arm, disarm, status read/write, memory read/write opcodes.
// - Opcodes 83h/82h select sector, lock status or lock by A10A9.
// - Sector access uses A5..A0 as byte index.
// - Unique-ID read uses A9 set and A3..A0 as byte index.
// - Status write changes only lock and guard bits.
// - Status read repeats the status byte while clocked.
// - Memory read takes 16-bit address and streams incrementing bytes.
// - Memory write wraps within its 64-byte page.
module spi_eeprom_cmd_protect #(
    parameter int TW_CYCLES = eeprom_pkg::TW_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic serial_in,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic serial_out,
    output logic serial_out_oe_n,
    output logic [15:0] rd_addr,
    output eeprom_pkg::space_t rd_space,
    input wire logic [7:0] rd_data,
    output logic wq_valid,
    input wire logic wq_ready,
    output logic [eeprom_pkg::WORD_W-1:0] wq_data
);
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic sck_d_q;
    logic cs_d_q;
    logic hold_q;
    logic [2:0] bits_q;
    logic [2:0] bytes_q;
    logic [7:0] sr_in_q;
    logic [7:0] addr_hi_q;
    eeprom_pkg::op_t op_q;
    eeprom_pkg::op_t op_dec;
    eeprom_pkg::space_t space_q;
    logic [15:0] ptr_q;
    logic wr_ok_q;
    logic pushed_q;
    logic overrun_q;
    logic [6:0] out_sr_q;
    logic so_q;
    logic drive_q;
    logic oe_n_q;
    logic write_latch_flag_q;
    logic busy_flag_q;
    logic region_guard_hi_q;
    logic region_guard_lo_q;
    logic status_lock_bit_q;
    logic [eeprom_pkg::TW_W-1:0] tw_cnt_q;
    logic pend_q;
    eeprom_pkg::kind_t pend_kind_q;
    eeprom_pkg::space_t pend_space_q;
    logic [7:0] status_word;
    logic fifo_in_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    wire cs_s = sync2_q[eeprom_pkg::SY_CS];
    wire sck_s = sync2_q[eeprom_pkg::SY_SCK];
    wire si_s = sync2_q[eeprom_pkg::SY_SI];
    wire hold_s = sync2_q[eeprom_pkg::SY_HOLD];
    wire wp_s = sync2_q[eeprom_pkg::SY_WP];
    // Edges only count while selected, so either idle level is harmless
    wire sck_rise = sck_s & ~sck_d_q & ~cs_s & ~hold_q;
    wire sck_fall = ~sck_s & sck_d_q & ~cs_s & ~hold_q;
    wire cs_rise = cs_s & ~cs_d_q;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sync1_q <= eeprom_pkg::SYNC_RST;
            sync2_q <= eeprom_pkg::SYNC_RST;
            sck_d_q <= 1'b0;
            cs_d_q <= 1'b1;
        end else begin
            sync1_q <= {wp_n, hold_n, serial_in, sck, cs_n};
            sync2_q <= sync1_q;
            sck_d_q <= sck_s;
            cs_d_q <= cs_s;
        end
    end

    // Pause follows the pause pin only while the clock is low
    always_ff @(posedge sys_clk) begin
        if (!reset_n || cs_s) begin
            hold_q <= 1'b0;
        end else if (!sck_s) begin
            hold_q <= ~hold_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Framing and decode
    wire [7:0] in_byte = {sr_in_q[6:0], si_s};
    wire byte_done = sck_rise & (bits_q == 3'h7);
    wire [15:0] addr_full = {addr_hi_q, in_byte};
    wire addr_done = byte_done & (bytes_q == eeprom_pkg::BYTE_ALO);
    wire data_byte = byte_done & (bytes_q >= eeprom_pkg::BYTE_DATA);
    wire [1:0] a10a9 = addr_full[10:9];
    wire is_xr = op_q == eeprom_pkg::OP_XREAD;
    wire is_xw = op_q == eeprom_pkg::OP_XWRITE;
    wire is_mw = op_q == eeprom_pkg::OP_WRITE;
    wire is_rd = (op_q == eeprom_pkg::OP_READ) | is_xr;
    wire x_bad = is_xw & a10a9[0];
    wire [1:0] guard = {region_guard_hi_q, region_guard_lo_q};
    wire [14:0] a15 = addr_full[14:0];
    wire prot = (guard == 2'h3) | (guard == 2'h2 & a15 >= eeprom_pkg::HALF_BASE)
        | (guard == 2'h1 & a15 >= eeprom_pkg::QUARTER_BASE);
    wire hw_lock = status_lock_bit_q & ~wp_s;
    eeprom_pkg::space_t x_sp;
    eeprom_pkg::space_t addr_sp;
    assign x_sp = (is_xr & a10a9[0]) ? eeprom_pkg::SP_UID
        : (a10a9 == 2'h0) ? eeprom_pkg::SP_SECTOR : eeprom_pkg::SP_LOCK;
    assign addr_sp = (is_xr | is_xw) ? x_sp : eeprom_pkg::SP_ARRAY;

    always_comb begin
        unique case (in_byte)
            eeprom_pkg::OPC_ARM: op_dec = eeprom_pkg::OP_ARM;
            eeprom_pkg::OPC_DISARM: op_dec = eeprom_pkg::OP_DISARM;
            eeprom_pkg::OPC_SREAD: op_dec = eeprom_pkg::OP_SREAD;
            eeprom_pkg::OPC_SWRITE: op_dec = eeprom_pkg::OP_SWRITE;
            eeprom_pkg::OPC_READ: op_dec = eeprom_pkg::OP_READ;
            eeprom_pkg::OPC_WRITE: op_dec = eeprom_pkg::OP_WRITE;
            eeprom_pkg::OPC_XREAD: op_dec = eeprom_pkg::OP_XREAD;
            eeprom_pkg::OPC_XWRITE: op_dec = eeprom_pkg::OP_XWRITE;
            default: op_dec = eeprom_pkg::OP_NONE;
        endcase
    end

    wire opc_done = byte_done & (bytes_q == eeprom_pkg::BYTE_OPC);
    wire busy_drop = busy_flag_q & (op_dec != eeprom_pkg::OP_SREAD);

    always_ff @(posedge sys_clk) begin
        if (!reset_n || cs_s) begin
            op_q <= eeprom_pkg::OP_NONE;
            bits_q <= '0;
            bytes_q <= eeprom_pkg::BYTE_OPC;
        end else if (sck_rise) begin
            sr_in_q <= in_byte;
            bits_q <= bits_q + 3'h1;
            if (byte_done && bytes_q != eeprom_pkg::BYTE_SAT) begin
                bytes_q <= bytes_q + 3'h1;
            end
            if (opc_done) begin
                op_q <= busy_drop ? eeprom_pkg::OP_NONE : op_dec;
            end else if (addr_done && x_bad) begin
                op_q <= eeprom_pkg::OP_NONE;
            end
            if (byte_done && bytes_q == eeprom_pkg::BYTE_AHI) begin
                addr_hi_q <= in_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address pointer and write path
    wire [15:0] inc_all = ptr_q + 16'h1;
    wire [15:0] inc_page = {ptr_q[15:6], ptr_q[5:0] + 6'h1};
    wire [15:0] inc_uid = {ptr_q[15:4], ptr_q[3:0] + 4'h1};
    wire [15:0] ptr_next = (space_q == eeprom_pkg::SP_UID) ? inc_uid
        : (space_q == eeprom_pkg::SP_SECTOR || is_mw) ? inc_page : inc_all;
    wire wr_op = is_mw | (is_xw & space_q == eeprom_pkg::SP_SECTOR);
    wire push_data = data_byte & wr_ok_q & wr_op;
    wire push_ok = fifo_in_ready & ~pend_q;
    wire base_ok = cs_rise & (bits_q == 3'h0) & ~hold_q & wr_ok_q & ~overrun_q;
    wire commit = base_ok & ((wr_op & bytes_q == eeprom_pkg::BYTE_SAT)
        | (is_xw & space_q == eeprom_pkg::SP_LOCK & bytes_q >= eeprom_pkg::BYTE_DATA));
    wire abort = cs_rise & pushed_q & ~commit;
    wire pend_take = pend_q & fifo_in_ready;

    always_ff @(posedge sys_clk) begin
        if (!reset_n || cs_s) begin
            wr_ok_q <= 1'b0;
            pushed_q <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            if (addr_done) begin
                ptr_q <= addr_full;
                space_q <= addr_sp;
                wr_ok_q <= write_latch_flag_q & ((is_mw & ~prot) | (is_xw & ~x_bad));
            end else if (data_byte && (is_rd || push_data)) begin
                ptr_q <= ptr_next;
            end
            pushed_q <= pushed_q | (push_data & push_ok);
            overrun_q <= overrun_q | (push_data & ~push_ok);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pend_q <= 1'b0;
        end else if (commit || abort) begin
            pend_q <= 1'b1;
            pend_kind_q <= commit ? eeprom_pkg::K_COMMIT : eeprom_pkg::K_ABORT;
            pend_space_q <= space_q;
        end else if (pend_take) begin
            pend_q <= 1'b0;
        end
    end

    word_fifo #(
        .WIDTH(eeprom_pkg::WORD_W),
        .DEPTH(eeprom_pkg::FIFO_DEPTH)
    ) u_wq (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_valid(pend_q | push_data),
        .in_ready(fifo_in_ready),
        .in_data(pend_q ? {pend_space_q, pend_kind_q, 24'h0}
            : {space_q, eeprom_pkg::K_DATA, ptr_q, in_byte}),
        .out_valid(wq_valid),
        .out_ready(wq_ready),
        .out_data(wq_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status register and write cycle timer
    wire exec_base = cs_rise & (bits_q == 3'h0) & ~hold_q;
    wire arm_exec = exec_base & (op_q == eeprom_pkg::OP_ARM);
    wire disarm_exec = exec_base & (op_q == eeprom_pkg::OP_DISARM);
    wire sw_exec = exec_base & (op_q == eeprom_pkg::OP_SWRITE) & write_latch_flag_q
        & ~hw_lock & (bytes_q >= eeprom_pkg::BYTE_ALO);
    wire tw_load = sw_exec | (pend_take & pend_kind_q == eeprom_pkg::K_COMMIT);

    always_comb begin
        status_word = 8'h00;
        status_word[eeprom_pkg::ST_BUSY] = busy_flag_q;
        status_word[eeprom_pkg::ST_WLATCH] = write_latch_flag_q;
        status_word[eeprom_pkg::ST_GUARD_LO] = region_guard_lo_q;
        status_word[eeprom_pkg::ST_GUARD_HI] = region_guard_hi_q;
        status_word[eeprom_pkg::ST_LOCK] = status_lock_bit_q;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            write_latch_flag_q <= 1'b0;
            region_guard_hi_q <= eeprom_pkg::GUARD_RST[1];
            region_guard_lo_q <= eeprom_pkg::GUARD_RST[0];
            status_lock_bit_q <= eeprom_pkg::LOCK_RST;
            busy_flag_q <= 1'b0;
            tw_cnt_q <= '0;
        end else begin
            if (disarm_exec || sw_exec || commit) begin
                write_latch_flag_q <= 1'b0;
            end else if (arm_exec) begin
                write_latch_flag_q <= 1'b1;
            end
            if (sw_exec) begin
                region_guard_hi_q <= sr_in_q[eeprom_pkg::ST_GUARD_HI];
                region_guard_lo_q <= sr_in_q[eeprom_pkg::ST_GUARD_LO];
                status_lock_bit_q <= sr_in_q[eeprom_pkg::ST_LOCK];
            end
            if (tw_load) begin
                tw_cnt_q <= eeprom_pkg::TW_W'(TW_CYCLES);
            end else if (tw_cnt_q != '0) begin
                tw_cnt_q <= tw_cnt_q - 1'b1;
            end
            busy_flag_q <= commit | sw_exec | tw_load | (tw_cnt_q > 1)
                | (pend_q & pend_kind_q == eeprom_pkg::K_COMMIT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial output
    wire out_phase = (op_q == eeprom_pkg::OP_SREAD) | (is_rd & bytes_q >= eeprom_pkg::BYTE_DATA);
    wire [7:0] out_src = (op_q == eeprom_pkg::OP_SREAD) ? status_word : rd_data;
    wire out_load = sck_fall & out_phase & (bits_q == 3'h0);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            so_q <= 1'b0;
            out_sr_q <= '0;
            drive_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            if (out_load) begin
                {so_q, out_sr_q} <= out_src;
            end else if (sck_fall && out_phase) begin
                {so_q, out_sr_q} <= {out_sr_q, 1'b0};
            end
            drive_q <= ~cs_s & (drive_q | out_load);
            oe_n_q <= cs_s | hold_q | ~(drive_q | out_load);
        end
    end

    assign serial_out = so_q;
    assign serial_out_oe_n = oe_n_q;
    assign rd_addr = ptr_q;
    assign rd_space = space_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    AST_HOLD_FLOATS: assert property (hold_q |=> oe_n_q)
        else $error("output driven during pause");
    AST_HOLD_ENTER: assert property (!cs_s && !hold_s && !sck_s && !hold_q |=> hold_q)
        else $error("pause did not start with clock low");
    AST_ARM_SETS: assert property (arm_exec && !disarm_exec |=> write_latch_flag_q)
        else $error("arm-write did not set write latch");
    AST_WRITE_CLEARS: assert property (sw_exec || commit |=> !write_latch_flag_q [*2])
        else $error("write latch left set after write");
    AST_BUSY_ONLY_SREAD: assert property (opc_done && busy_flag_q
        && op_dec != eeprom_pkg::OP_SREAD |=> op_q == eeprom_pkg::OP_NONE)
        else $error("instruction accepted while busy");
    AST_LOCKED_STABLE: assert property (hw_lock && cs_rise |=>
        $stable({status_lock_bit_q, region_guard_hi_q, region_guard_lo_q}))
        else $error("status changed while locked");
    AST_BUSY_CYCLE: assert property (sw_exec |=> busy_flag_q [*3])
        else $error("busy not raised for status write");
    AST_PARTIAL_BYTE: assert property (cs_rise && bits_q != 3'h0 && !busy_flag_q
        |=> !busy_flag_q && !(pend_q && pend_kind_q == eeprom_pkg::K_COMMIT))
        else $error("write executed off byte boundary");
    AST_NO_PROT_PUSH: assert property (addr_done && is_mw && prot |=> !wr_ok_q)
        else $error("protected address accepted");
    AST_RESERVED_ZERO: assert property (status_word[6:4] == 3'h0)
        else $error("reserved status bits nonzero");

    COV_STATUS_READ: cover property (out_load && op_q == eeprom_pkg::OP_SREAD);
    COV_COMMIT: cover property (commit && is_mw);
    COV_PAUSE_RESUME: cover property (hold_q ##1 !hold_q [*2] ##[1:50] sck_rise);
endmodule

`default_nettype wire

// [tb/spi_eeprom_cmd_protect_tb.sv]
/*
 Self-checking bench: status, write latch, guards, lock, pause, reads and write queue.
 Assumes the master model; the array side answers rd_data from rd_addr.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_cmd_protect_tb;
    localparam int TW = 300;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic wp_n;
    logic wq_ready;
    logic [7:0] rd_data;
    wire logic cs_n, sck, mosi, hold_n, so, so_oe_n, wq_valid;
    // Released data line floats to its pull-up
    wire logic miso_line = so_oe_n ? 1'b1 : so;
    logic [15:0] rd_addr;
    eeprom_pkg::space_t rd_space;
    logic [27:0] wq_data;
    logic [27:0] wq_log[$];
    logic [7:0] v;
    logic [7:0] w;
    int mismatches = 0;
    int cmp_count = 0;
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) rd_data <= #1 rd_addr[7:0] ^ 8'h5a;
    always @(posedge sys_clk) if (reset_n && wq_valid && wq_ready) wq_log.push_back(wq_data);
    spi_master_model u_mst (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .mosi(mosi),
        .hold_n(hold_n), .miso(miso_line));
    spi_eeprom_cmd_protect #(.TW_CYCLES(TW)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .cs_n(cs_n), .sck(sck), .serial_in(mosi), .hold_n(hold_n), .wp_n(wp_n),
        .serial_out(so), .serial_out_oe_n(so_oe_n), .rd_addr(rd_addr), .rd_space(rd_space),
        .rd_data(rd_data), .wq_valid(wq_valid), .wq_ready(wq_ready), .wq_data(wq_data));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkw(input logic [27:0] got, input logic [27:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t queue word %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] ncommit();
        logic [7:0] c;
        c = 8'h00;
        foreach (wq_log[i]) if (wq_log[i][25:24] === 2'h1) c++;
        return c;
    endfunction
    task automatic cmd(input logic [7:0] op, input logic m3);
        logic [7:0] r;
        u_mst.frame_on(m3);
        u_mst.shift(op, 8, r);
        u_mst.frame_off();
    endtask
    task automatic rdst(output logic [7:0] s);
        u_mst.frame_on(1'b0);
        u_mst.shift(eeprom_pkg::OPC_SREAD, 8, s);
        u_mst.shift(8'h00, 8, s);
        u_mst.frame_off();
    endtask
    // Opcode, address unless status write, n data bytes, xb stray bits
    task automatic wr(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d,
                      input int n, input int xb);
        logic [7:0] r;
        u_mst.frame_on(1'b0);
        u_mst.shift(op, 8, r);
        if (op !== eeprom_pkg::OPC_SWRITE) begin
            u_mst.shift(a[15:8], 8, r);
            u_mst.shift(a[7:0], 8, r);
        end
        for (int k = 0; k < n; k++) u_mst.shift(d + 8'(k), 8, r);
        if (xb > 0) u_mst.shift(8'hff, xb, r);
        u_mst.frame_off();
    endtask
    task automatic rd2(input logic [7:0] op, input logic [15:0] a, output logic [7:0] b0,
                       output logic [7:0] b1);
        u_mst.frame_on(1'b0);
        u_mst.shift(op, 8, b0);
        u_mst.shift(a[15:8], 8, b0);
        u_mst.shift(a[7:0], 8, b0);
        u_mst.shift(8'h00, 8, b0);
        u_mst.shift(8'h00, 8, b1);
        u_mst.frame_off();
    endtask
    task automatic wait_idle();
        v = 8'h01;
        for (int k = 0; k < 20 && v[0] !== 1'b0; k++) rdst(v);
    endtask
    task automatic close_out();
        $display("TB: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #2_000_000;
        mismatches++;
        close_out();
    end
    initial begin
        wp_n = 1'b1;
        wq_ready = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        u_mst.tick(4);
        rdst(v);
        chk8(v, 8'h00);
        wr(eeprom_pkg::OPC_WRITE, 16'h0010, 8'ha0, 1, 0);
        chk8(ncommit(), 8'h00);
        cmd(eeprom_pkg::OPC_ARM, 1'b1);
        rdst(v);
        chk8(v, 8'h02);
        cmd(eeprom_pkg::OPC_DISARM, 1'b1);
        rdst(v);
        chk8(v, 8'h00);
        $display("test latch done");
        cmd(eeprom_pkg::OPC_ARM, 1'b0);
        wq_log.delete();
        wr(eeprom_pkg::OPC_WRITE, 16'h003e, 8'hd0, 3, 0);
        rdst(v);
        chk8(v, 8'h01);
        cmd(eeprom_pkg::OPC_ARM, 1'b0);
        wait_idle();
        chk8(v, 8'h00);
        for (int k = 0; k < 3; k++) chkw(wq_log[k], {12'h000, 6'h3e + 6'(k), 8'hd0 + 8'(k)});
        chk8({6'h00, wq_log[3][25:24]}, 8'h01);
        $display("test page write done");
        cmd(eeprom_pkg::OPC_ARM, 1'b0);
        wq_log.delete();
        wr(eeprom_pkg::OPC_WRITE, 16'h0100, 8'h11, 1, 3);
        rdst(v);
        chk8(v, 8'h02);
        chk8(ncommit(), 8'h00);
        wq_ready = 1'b0;
        wr(eeprom_pkg::OPC_WRITE, 16'h0200, 8'h20, 9, 0);
        wq_ready = 1'b1;
        u_mst.tick(40);
        rdst(v);
        chk8(v, 8'h02);
        chk8({6'h00, wq_log[$][25:24]}, 8'h02);
        $display("test refused writes done");
        wr(eeprom_pkg::OPC_SWRITE, 16'h0000, 8'hfc, 1, 0);
        rdst(v);
        chk8(v, 8'h8d);
        wait_idle();
        chk8(v, 8'h8c);
        cmd(eeprom_pkg::OPC_ARM, 1'b0);
        wr(eeprom_pkg::OPC_WRITE, 16'h0010, 8'h33, 1, 0);
        rdst(v);
        chk8(v, 8'h8e);
        wp_n = 1'b0;
        wr(eeprom_pkg::OPC_SWRITE, 16'h0000, 8'h04, 1, 0);
        rdst(v);
        chk8(v, 8'h8e);
        wp_n = 1'b1;
        wr(eeprom_pkg::OPC_SWRITE, 16'h0000, 8'h04, 1, 0);
        wait_idle();
        chk8(v, 8'h04);
        cmd(eeprom_pkg::OPC_ARM, 1'b0);
        wr(eeprom_pkg::OPC_WRITE, 16'h6000, 8'h44, 1, 0);
        rdst(v);
        chk8(v, 8'h06);
        wr(eeprom_pkg::OPC_WRITE, 16'h5fff, 8'h45, 1, 0);
        rdst(v);
        chk8(v, 8'h05);
        wait_idle();
        $display("test protection done");
        rd2(eeprom_pkg::OPC_READ, 16'h0010, v, w);
        chk8(v, 8'h4a);
        chk8(w, 8'h4b);
        rd2(eeprom_pkg::OPC_XREAD, 16'hf905, v, w);
        chk8(v, 8'h5f);
        chk8({6'h00, rd_space}, 8'h01);
        rd2(eeprom_pkg::OPC_XREAD, 16'h0203, v, w);
        chk8(v, 8'h59);
        chk8({6'h00, rd_space}, 8'h02);
        rd2(eeprom_pkg::OPC_XREAD, 16'h0400, v, w);
        chk8({6'h00, rd_space}, 8'h03);
        $display("test reads done");
        u_mst.frame_on(1'b0);
        u_mst.shift(eeprom_pkg::OPC_SREAD, 8, v);
        u_mst.shift(8'h00, 4, v);
        u_mst.pause_on();
        chk8({7'h00, so_oe_n}, 8'h01);
        u_mst.pause_off();
        u_mst.shift(8'h00, 4, w);
        u_mst.frame_off();
        chk8({v[3:0], w[3:0]}, 8'h04);
        $display("test pause done");
        close_out();
    end
endmodule
`default_nettype wire

// [tb/spi_master_model.sv]
/*
 SPI bus master model: drives select, clock, data and pause toward the EEPROM front end.
 Assumes a 40 MHz sys_clk; one link half period is four sys_clk cycles (200 ns period).
*/
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    input wire logic sys_clk,
    output logic cs_n,
    output logic sck,
    output logic mosi,
    output logic hold_n,
    input wire logic miso
);
    logic mode3 = 1'b0;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
        hold_n = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Clock sits at the mode's idle level across both select edges
    task automatic frame_on(input logic m3);
        mode3 = m3;
        sck = m3;
        tick(4);
        cs_n = 1'b0;
        tick(4);
    endtask
    task automatic frame_off();
        sck = mode3;
        tick(4);
        cs_n = 1'b1;
        mosi = ~mosi;
        tick(8);
    endtask
    // Data set while clock low, slave takes it on the rise
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < n; i++) begin
            sck = 1'b0;
            mosi = tx[7-i];
            tick(4);
            sck = 1'b1;
            tick(4);
            rx = {rx[6:0], miso};
        end
    endtask
    // Select stays low for the whole pause; clock wiggles meanwhile
    task automatic pause_on();
        sck = 1'b0;
        tick(4);
        hold_n = 1'b0;
        tick(4);
        repeat (2) begin
            sck = 1'b1;
            tick(4);
            sck = 1'b0;
            tick(4);
        end
    endtask
    task automatic pause_off();
        hold_n = 1'b1;
        tick(8);
    endtask
endmodule
`default_nettype wire
